// ### hdl/tap_guard.sv
/*
  timed write guard: key sequence on the access key register opens a short
  window during which protected watchdog control bits may be written.
  assumes the cpu presents every sfr write, including bit and
  read-modify-write forms, as one merged byte on sfr_wr for one clock,
  and pulses mc_tick once per machine cycle.
*/
// Function
// - a write to a protected bit takes effect only while the window is open, else it is dropped.
// - a write of aah to the key register starts a count watching for 55h within 3 machine cycles.
// - a timely 55h write opens the window for 3 machine cycles, after which it closes by itself.
// - the key register is decoded at special-function address c7h.
// - a 55h write landing 4 machine cycles after aah does not open the window.
// - only the low four watchdog control bits (mask 0fh) are guarded by the window; the upper four are always writable.
`default_nettype none
module tap_guard #(
  parameter int unsigned KEY_WAIT_MC = tap_pkg::KEY_WAIT_MC,
  parameter int unsigned OPEN_MC = tap_pkg::OPEN_MC,
  parameter logic [7:0] PROT_MASK = tap_pkg::WDC_PROT_MASK
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic mc_tick,
  input wire tap_pkg::tap_sfr_wr_s sfr_wr,
  output logic window_open,
  output logic key_armed,
  output logic [7:0] watchdog_control
);
  tap_pkg::tap_regs_s r_q;
  tap_pkg::tap_regs_s r_d;
  logic restart;
  logic [tap_pkg::CNT_W-1:0] cnt;
  logic key_wr;
  logic wdc_wr;
  logic [7:0] wr_mask;

  localparam logic [tap_pkg::CNT_W-1:0] KEY_LAST = tap_pkg::CNT_W'(KEY_WAIT_MC);
  localparam logic [tap_pkg::CNT_W-1:0] OPEN_LAST = tap_pkg::CNT_W'(OPEN_MC);

  tap_mc_count #(
    .W(tap_pkg::CNT_W)
  ) u_count (
    .ref_clk(ref_clk),
    .rst(rst),
    .restart(restart),
    .tick(mc_tick),
    .count(cnt)
  );

  assign key_wr = sfr_wr.en && (sfr_wr.addr == tap_pkg::KEY_ADDR);
  assign wdc_wr = sfr_wr.en && (sfr_wr.addr == tap_pkg::WDC_ADDR);

  always_comb
  begin
    r_d = r_q;
    restart = 1'b0;
    case (r_q.st)
      tap_pkg::TAP_IDLE:
      begin
        if (key_wr && (sfr_wr.data == tap_pkg::KEY_FIRST))
        begin
          r_d.st = tap_pkg::TAP_ARMED;
          restart = 1'b1;
        end
      end
      tap_pkg::TAP_ARMED:
      begin
        // the key write wins over a tick in the same clock
        if (key_wr && (sfr_wr.data == tap_pkg::KEY_SECOND))
        begin
          r_d.st = tap_pkg::TAP_OPEN;
          restart = 1'b1;
        end
        else if (key_wr && (sfr_wr.data == tap_pkg::KEY_FIRST))
        begin
          restart = 1'b1;
        end
        else if (key_wr)
        begin
          r_d.st = tap_pkg::TAP_IDLE;
        end
        else if (mc_tick && (cnt >= KEY_LAST))
        begin
          r_d.st = tap_pkg::TAP_IDLE;
        end
      end
      tap_pkg::TAP_OPEN:
      begin
        if (key_wr && (sfr_wr.data == tap_pkg::KEY_FIRST))
        begin
          r_d.st = tap_pkg::TAP_ARMED;
          restart = 1'b1;
        end
        else if (mc_tick && (cnt >= OPEN_LAST))
        begin
          // back to idle: only a fresh key pair reopens
          r_d.st = tap_pkg::TAP_IDLE;
        end
      end
      default:
      begin
        r_d.st = tap_pkg::TAP_IDLE;
      end
    endcase
    // protected bits follow the window, the rest are always writable
    wr_mask = (r_q.st == tap_pkg::TAP_OPEN) ? 8'hff : ~PROT_MASK;
    if (wdc_wr)
    begin
      r_d.wdc = (r_q.wdc & ~wr_mask) | (sfr_wr.data & wr_mask);
    end
    r_d.open = (r_d.st == tap_pkg::TAP_OPEN);
    r_d.armed = (r_d.st == tap_pkg::TAP_ARMED);
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      r_q <= '{st: tap_pkg::TAP_IDLE, open: 1'b0, armed: 1'b0, wdc: tap_pkg::WDC_RESET};
    end
    else
    begin
      r_q <= r_d;
    end
  end

  assign window_open = r_q.open;
  assign key_armed = r_q.armed;
  assign watchdog_control = r_q.wdc;

  sequence key_first_s;
    key_wr && (sfr_wr.data == tap_pkg::KEY_FIRST);
  endsequence

  sequence key_second_s;
    key_wr && (sfr_wr.data == tap_pkg::KEY_SECOND);
  endsequence

  arm_on_first_a: assert property (@(posedge ref_clk) disable iff (rst)
    key_first_s |=> key_armed && (cnt == '0))
    else $error("key aah did not arm the guard");

  key_in_time_a: assert property (@(posedge ref_clk) disable iff (rst)
    key_armed ##0 key_second_s |=> window_open && !key_armed)
    else $error("timely 55h did not open the window");

  late_key_a: assert property (@(posedge ref_clk) disable iff (rst)
    key_armed && !key_wr && mc_tick && (cnt == KEY_LAST) |=> !key_armed && !window_open)
    else $error("armed guard survived past the key wait");

  window_close_a: assert property (@(posedge ref_clk) disable iff (rst)
    window_open && !key_wr && mc_tick && (cnt == OPEN_LAST) |=> !window_open)
    else $error("window stayed open past its length");

  window_bound_a: assert property (@(posedge ref_clk) disable iff (rst)
    window_open |-> (cnt <= OPEN_LAST))
    else $error("window open with count beyond its length");

  open_cause_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(window_open) |-> $past(key_armed) && $past(key_wr)
      && ($past(sfr_wr.data) == tap_pkg::KEY_SECOND))
    else $error("window opened without a key pair");

  closed_drop_a: assert property (@(posedge ref_clk) disable iff (rst)
    wdc_wr && !window_open |=> (($past(watchdog_control) ^ watchdog_control) & PROT_MASK) == 8'h00)
    else $error("protected bit changed with the window closed");

  open_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    wdc_wr && window_open |=> watchdog_control == $past(sfr_wr.data))
    else $error("write inside the window was not taken");

  free_bits_a: assert property (@(posedge ref_clk) disable iff (rst)
    wdc_wr |=> ((watchdog_control ^ $past(sfr_wr.data)) & ~PROT_MASK) == 8'h00)
    else $error("unprotected bits did not follow the write");

  // last tick of the key wait
  sequence key_expire_s;
    mc_tick && (cnt == KEY_LAST);
  endsequence

  // last tick of the open window
  sequence open_expire_s;
    window_open && mc_tick && (cnt == OPEN_LAST);
  endsequence

  state_excl_a: assert property (@(posedge ref_clk) disable iff (rst)
    !(window_open && key_armed))
    else $error("guard armed and open at once");

  arm_bound_a: assert property (@(posedge ref_clk) disable iff (rst)
    key_armed |-> (cnt <= KEY_LAST))
    else $error("armed guard with count beyond its wait");

  stray_key_a: assert property (@(posedge ref_clk) disable iff (rst)
    key_armed && key_wr && (sfr_wr.data != tap_pkg::KEY_FIRST)
      && (sfr_wr.data != tap_pkg::KEY_SECOND) |=> !key_armed && !window_open)
    else $error("stray key byte did not cancel the wait");

  open_rearm_a: assert property (@(posedge ref_clk) disable iff (rst)
    window_open ##0 key_first_s |=> key_armed && !window_open)
    else $error("key aah inside the window did not re-arm");

  open_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    window_open && !(key_wr && (sfr_wr.data == tap_pkg::KEY_FIRST))
      && !(mc_tick && (cnt == OPEN_LAST)) |=> window_open)
    else $error("window closed early");

  armed_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    key_armed && !key_wr && !(mc_tick && (cnt == KEY_LAST)) |=> key_armed)
    else $error("key wait ended early");

  idle_quiet_a: assert property (@(posedge ref_clk) disable iff (rst)
    !key_armed && !window_open && !(key_wr && (sfr_wr.data == tap_pkg::KEY_FIRST))
      |=> !key_armed && !window_open)
    else $error("guard left idle without key aah");

  wdc_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    !wdc_wr |=> $stable(watchdog_control))
    else $error("watchdog control changed without a write");

  addr_decode_a: assert property (@(posedge ref_clk) disable iff (rst)
    sfr_wr.en && (sfr_wr.addr != tap_pkg::KEY_ADDR) && !key_armed && !window_open
      |=> !key_armed && !window_open)
    else $error("write to another address moved the guard");

  late_tie_a: assert property (@(posedge ref_clk) disable iff (rst)
    key_armed ##0 key_second_s ##0 key_expire_s |=> window_open)
    else $error("55h on the last wait tick was lost");

  close_tie_a: assert property (@(posedge ref_clk) disable iff (rst)
    open_expire_s ##0 key_first_s |=> key_armed)
    else $error("aah on the last window tick was lost");
endmodule
`default_nettype wire

// ### hdl/tap_mc_count.sv
/*
  saturating count of machine-cycle ticks since the last restart.
  assumes tick is a one-clock pulse per machine cycle.
*/
`default_nettype none
module tap_mc_count #(
  parameter int unsigned W = tap_pkg::CNT_W
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic restart,
  input wire logic tick,
  output logic [W-1:0] count
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  always_comb
  begin
    cnt_d = cnt_q;
    if (restart)
    begin
      cnt_d = '0;
    end
    else if (tick && (cnt_q != {W{1'b1}}))
    begin
      // saturate so a long idle gap never wraps back into range
      cnt_d = cnt_q + W'(1);
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= '0;
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end

  assign count = cnt_q;
endmodule
`default_nettype wire

// ### hdl/tap_pkg.sv
/*
  shared constants and carrier types for the timed write guard.
  assumes an 8-bit special-function write port driven by the cpu core.
*/
`default_nettype none
package tap_pkg;
  // special-function addresses
  localparam logic [7:0] KEY_ADDR = 8'hc7;
  localparam logic [7:0] WDC_ADDR = 8'hd8;
  // key bytes
  localparam logic [7:0] KEY_FIRST = 8'haa;
  localparam logic [7:0] KEY_SECOND = 8'h55;
  // watchdog control reset value and the bits that need the open window
  localparam logic [7:0] WDC_RESET = 8'h00;
  localparam logic [7:0] WDC_PROT_MASK = 8'h0f;
  // timing in machine cycles
  localparam int unsigned KEY_WAIT_MC = 3;
  localparam int unsigned OPEN_MC = 3;
  localparam int unsigned CNT_W = 3;

  typedef enum logic [1:0] {
    TAP_IDLE = 2'b00,
    TAP_ARMED = 2'b01,
    TAP_OPEN = 2'b10
  } tap_state_e;

  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } tap_sfr_wr_s;

  typedef struct packed {
    tap_state_e st;
    logic open;
    logic armed;
    logic [7:0] wdc;
  } tap_regs_s;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } tap_cnt_s;
endpackage
`default_nettype wire

// ### verif/tap_tb.sv
/*
  self-checking bench for the timed write guard: key sequences, window timing
  and protected watchdog control writes driven through the sfr write port.
  assumes tap_pkg and tap_guard are compiled first.
*/
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin fails++; \
  $display("ERROR at %0t: got %h expected %h", $time, got, exp); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk;
  logic rst;
  logic mc_tick;
  tap_pkg::tap_sfr_wr_s sfr_wr;
  logic window_open;
  logic key_armed;
  logic [7:0] watchdog_control;
  logic [7:0] exp_wdc;
  int fails;
  int cmp_count;

  tap_guard dut (
    .ref_clk(ref_clk),
    .rst(rst),
    .mc_tick(mc_tick),
    .sfr_wr(sfr_wr),
    .window_open(window_open),
    .key_armed(key_armed),
    .watchdog_control(watchdog_control)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // one write per call, strobe dropped at the taking edge, result checked 1 ns later
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sfr_wr <= '{en: 1'b1, addr: a, data: d};
    @(posedge ref_clk);
    sfr_wr.en <= 1'b0;
    #1;
  endtask

  // one write with a machine-cycle tick in the same clock
  task automatic wr_tick(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    mc_tick <= 1'b1;
    sfr_wr <= '{en: 1'b1, addr: a, data: d};
    @(posedge ref_clk);
    mc_tick <= 1'b0;
    sfr_wr.en <= 1'b0;
    #1;
  endtask

  // n machine-cycle ticks, kept apart from write clocks so counts stay exact
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge ref_clk);
      mc_tick <= 1'b1;
      @(posedge ref_clk);
      mc_tick <= 1'b0;
    end
    #1;
  endtask

  // a refused write still lands in the unprotected upper bits
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw,
                                       input logic ok);
    merge = ok ? nw : ((nw & ~tap_pkg::WDC_PROT_MASK) | (old & tap_pkg::WDC_PROT_MASK));
  endfunction

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    #20000;
    fails++;
    end_of_test();
  end

  initial
  begin
    rst = 1'b1;
    mc_tick = 1'b0;
    sfr_wr = '0;
    fails = 0;
    cmp_count = 0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    `CHK(window_open, 1'b0)
    `CHK(key_armed, 1'b0)
    exp_wdc = tap_pkg::WDC_RESET;
    `CHK(watchdog_control, exp_wdc)
    $display("test reset done");

    wr(tap_pkg::WDC_ADDR, 8'hff);
    exp_wdc = merge(exp_wdc, 8'hff, 1'b0);
    `CHK(watchdog_control, exp_wdc)
    $display("test closed write done");

    wr(tap_pkg::KEY_ADDR, tap_pkg::KEY_FIRST);
    `CHK(key_armed, 1'b1)
    tick(3);
    `CHK(key_armed, 1'b1)
    wr(tap_pkg::KEY_ADDR, tap_pkg::KEY_SECOND);
    `CHK(window_open, 1'b1)
    `CHK(key_armed, 1'b0)
    tick(3);
    wr(tap_pkg::WDC_ADDR, 8'h3a);
    exp_wdc = 8'h3a;
    `CHK(watchdog_control, exp_wdc)
    // merged read-modify-write byte in the same window
    wr(tap_pkg::WDC_ADDR, 8'h3b);
    exp_wdc = 8'h3b;
    `CHK(watchdog_control, exp_wdc)
    tick(1);
    `CHK(window_open, 1'b0)
    wr(tap_pkg::WDC_ADDR, 8'h05);
    exp_wdc = merge(exp_wdc, 8'h05, 1'b0);
    `CHK(watchdog_control, exp_wdc)
    $display("test open window done");

    wr(tap_pkg::KEY_ADDR, tap_pkg::KEY_FIRST);
    tick(4);
    `CHK(key_armed, 1'b0)
    wr(tap_pkg::KEY_ADDR, tap_pkg::KEY_SECOND);
    `CHK(window_open, 1'b0)
    wr(tap_pkg::WDC_ADDR, 8'hc4);
    exp_wdc = merge(exp_wdc, 8'hc4, 1'b0);
    `CHK(watchdog_control, exp_wdc)
    $display("test late key done");

    wr(8'hc6, tap_pkg::KEY_FIRST);
    `CHK(key_armed, 1'b0)
    wr(tap_pkg::KEY_ADDR, tap_pkg::KEY_SECOND);
    `CHK(window_open, 1'b0)
    $display("test wrong address done");

    wr(tap_pkg::KEY_ADDR, tap_pkg::KEY_FIRST);
    wr(tap_pkg::KEY_ADDR, 8'h12);
    `CHK(key_armed, 1'b0)
    wr(tap_pkg::KEY_ADDR, tap_pkg::KEY_FIRST);
    tick(2);
    wr(tap_pkg::KEY_ADDR, tap_pkg::KEY_FIRST);
    tick(3);
    `CHK(key_armed, 1'b1)
    wr_tick(tap_pkg::KEY_ADDR, tap_pkg::KEY_SECOND);
    `CHK(window_open, 1'b1)
    wr(tap_pkg::KEY_ADDR, 8'h12);
    `CHK(window_open, 1'b1)
    tick(3);
    wr_tick(tap_pkg::KEY_ADDR, tap_pkg::KEY_FIRST);
    `CHK(key_armed, 1'b1)
    `CHK(window_open, 1'b0)
    tick(4);
    `CHK(key_armed, 1'b0)
    $display("test key order done");
    end_of_test();
  end
endmodule
`undef CHK
`default_nettype wire
